// [include/tzrtc_params.svh]
/*
 Offsets, field positions, reset values and timing counts of the
 interval timer with real-time-clock mode. Included by the package
 and the design modules; holds definitions only.
*/
`ifndef TZRTC_PARAMS_SVH
`define TZRTC_PARAMS_SVH

// Offsets are register indices; the byte address is four times one
`define TZRTC_MODE_OFFSET 12'hd8
`define TZRTC_COUNT_OFFSET 12'hd9
`define TZRTC_IRQ_STATUS_OFFSET 12'he0
`define TZRTC_IRQ_CLEAR_OFFSET 12'he4
`define TZRTC_IRQ_ENABLE_OFFSET 12'he8
`define TZRTC_POWER_OFFSET 12'hec

`define TZRTC_MODE_RUN_BIT 7
`define TZRTC_MODE_RATE_HI 6
`define TZRTC_MODE_RATE_LO 4
`define TZRTC_MODE_RTC_BIT 0
`define TZRTC_MODE_WMASK 8'hf1
`define TZRTC_MODE_RESET 8'h00
`define TZRTC_COUNT_RESET 8'h00
`define TZRTC_IRQ_OVF_BIT 0
`define TZRTC_IRQ_WAKE_BIT 1
`define TZRTC_IRQ_RESET 2'h0
`define TZRTC_VECTOR 8'h08

`define TZRTC_CLK_NS 10
`define TZRTC_RTC_DIV 64
`define TZRTC_LOSC_HZ 32768

`endif

// [include/tzrtc_pkg.sv]
/*
 Types shared by the interval timer modules.
 Assumes tzrtc_params.svh sits in the include path.
*/
`include "tzrtc_params.svh"

package tzrtc_pkg;

	typedef enum logic [1:0] {
		tzrtc_normal,
		tzrtc_slow,
		tzrtc_green
	} tzrtc_power_t;

	typedef struct packed {
		logic run;
		logic [2:0] prescale_select;
		logic rtc_clock_select;
	} tzrtc_mode_t;

	// Overflow at bit 0, wake at bit 1, as software sees them
	typedef struct packed {
		logic wake;
		logic overflow;
	} tzrtc_event_t;

endpackage : tzrtc_pkg

// [rtl/tzrtc_prescaler.sv]
/*
 Instruction-clock prescaler and low-speed oscillator divider.
 Assumes cpu_tick and losc_tick are one-cycle pclk pulses.
*/
`timescale 1ns/1ns
`include "tzrtc_params.svh"

module tzrtc_prescaler
	import tzrtc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [2:0] prescale_select,
	input wire logic rtc_mode,
	input wire logic cpu_tick,
	input wire logic losc_tick,
	output logic tick
);

	logic [7:0] cpu_div;
	logic [5:0] rtc_div;
	logic [7:0] sel_mask;

	// 000 -> /256, each step halves, 111 -> /2
	function automatic logic [7:0] rate_mask(input logic [2:0] sel);
		rate_mask = 8'hff >> sel;
	endfunction : rate_mask

	assign sel_mask = rate_mask(prescale_select);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cpu_div <= 8'h00;
		else if (!run)
			cpu_div <= 8'h00;
		else if (cpu_tick)
			cpu_div <= cpu_div + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rtc_div <= 6'h00;
		else if (!run)
			rtc_div <= 6'h00;
		else if (losc_tick)
			rtc_div <= rtc_div + 6'h01;
	end

	// Rate field ignored in RTC mode
	always_comb
	begin
		if (!run)
			tick = 1'b0;
		else if (rtc_mode)
			tick = losc_tick && (rtc_div == 6'h3f);
		else
			tick = cpu_tick && ((cpu_div & sel_mask) == sel_mask);
	end

endmodule : tzrtc_prescaler

// [rtl/tzrtc_regs.sv]
/*
 Sticky event status, write-only clear, enable, level interrupt.
 Assumes one-cycle event pulses and one-cycle clear strobes.
*/
`timescale 1ns/1ns
`include "tzrtc_params.svh"

module tzrtc_regs
	import tzrtc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire tzrtc_event_t set_event,
	input wire tzrtc_event_t clear_event,
	input wire logic enable_write,
	input wire tzrtc_event_t enable_data,
	output tzrtc_event_t status,
	output tzrtc_event_t enable,
	output logic irq
);

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status <= `TZRTC_IRQ_RESET;
		else
			status <= set_event | (status & ~clear_event);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enable <= `TZRTC_IRQ_RESET;
		else if (enable_write)
			enable <= enable_data;
	end

	assign irq = |(status & enable);

endmodule : tzrtc_regs

// [rtl/tzrtc_timer.sv]
/*
 8-bit up-counting interval timer with real-time-clock mode,
 APB register slave, overflow interrupt and green-mode wake-up.
 Assumes cpu_tick pulses once per instruction cycle and losc_tick once
 per low-speed oscillator cycle, both synchronous to pclk.
*/
// The APB register port was chosen for this implementation.
// Contract
// - Counting happens only while the run bit is set.
// - Count register rises by one per selected timer clock tick.
// - Rolling from 0xff to 0x00 sets the overflow flag.
// - Overflow flag stays set until software clears it.
// - No reload: count continues from zero after overflow.
// - Enabled overflow requests an interrupt to vector 8.
// - Counts in normal, slow and green; overflow in green wakes.
// - Wake-up returns to the mode used before green.
// - Rate field 000 divides by 256, down to 111 dividing by 2.
// - Mode bit 0 selects instruction clock or real-time clock.
// - Real-time clock is low-speed oscillator divided by 64.
// - Real-time-clock mode ignores rate; interval is half a second.
// - Real-time-clock mode exists only with the internal RC option.
// - Count register at 0xd9 is read/write and resets to zero.
`timescale 1ns/1ns
`include "tzrtc_params.svh"

module tzrtc_timer
	import tzrtc_pkg::*;
#(
	parameter bit INTERNAL_RC_WITH_RTC_OPTION = 1'b1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_tick,
	input wire logic losc_tick,
	input wire logic enter_green,
	output logic irq,
	output logic [7:0] irq_vector,
	output logic green_active,
	output logic wake_pulse,
	output logic [1:0] power_mode
);

	tzrtc_mode_t mode;
	logic [7:0] timer_zero_count;
	logic tick;
	logic overflow;
	logic rtc_mode;
	logic setup_write;
	logic bus_write;
	logic bus_read;
	logic mapped;
	logic [7:0] wbyte;
	tzrtc_event_t status;
	tzrtc_event_t enable;
	tzrtc_event_t set_event;
	tzrtc_event_t clear_event;
	tzrtc_power_t power;
	tzrtc_power_t resume_mode;
	logic [7:0] next_count;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		// One aligned word per register index
		hit = (a == {o[9:0], 2'b00});
	endfunction : hit

	// Slave answers in the first access cycle, no wait states
	assign pready = 1'b1;
	assign bus_write = psel && penable && pwrite;
	assign bus_read = psel && !pwrite;
	assign setup_write = bus_write && pstrb[0];
	assign wbyte = pwdata[7:0];

	always_comb
	begin
		mapped = hit(paddr, `TZRTC_MODE_OFFSET) ||
			hit(paddr, `TZRTC_COUNT_OFFSET) ||
			hit(paddr, `TZRTC_IRQ_STATUS_OFFSET) ||
			hit(paddr, `TZRTC_IRQ_CLEAR_OFFSET) ||
			hit(paddr, `TZRTC_IRQ_ENABLE_OFFSET) ||
			hit(paddr, `TZRTC_POWER_OFFSET);
	end

	assign pslverr = psel && penable && !mapped;

	// Without the option strap the source bit is held at zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode <= tzrtc_mode_t'(5'(`TZRTC_MODE_RESET));
		else if (setup_write && hit(paddr, `TZRTC_MODE_OFFSET))
		begin
			mode.run <= wbyte[`TZRTC_MODE_RUN_BIT];
			mode.prescale_select <=
				wbyte[`TZRTC_MODE_RATE_HI:`TZRTC_MODE_RATE_LO];
			mode.rtc_clock_select <= wbyte[`TZRTC_MODE_RTC_BIT] &&
				INTERNAL_RC_WITH_RTC_OPTION;
		end
	end

	assign rtc_mode = mode.rtc_clock_select;

	tzrtc_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.run(mode.run),
		.prescale_select(mode.prescale_select),
		.rtc_mode(rtc_mode),
		.cpu_tick(cpu_tick),
		.losc_tick(losc_tick),
		.tick(tick)
	);

	// A write in the same cycle as a tick wins; counting resumes after
	always_comb
	begin
		next_count = timer_zero_count;
		if (setup_write && hit(paddr, `TZRTC_COUNT_OFFSET))
			next_count = wbyte;
		else if (tick)
			next_count = timer_zero_count + 8'h01;
	end

	assign overflow = tick && (timer_zero_count == 8'hff) &&
		!(setup_write && hit(paddr, `TZRTC_COUNT_OFFSET));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_zero_count <= `TZRTC_COUNT_RESET;
		else
			timer_zero_count <= next_count;
	end

	// Green mode: timer keeps counting, overflow wakes the system
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			power <= tzrtc_normal;
			resume_mode <= tzrtc_normal;
		end
		else
		begin
			unique case (power)
				tzrtc_normal, tzrtc_slow:
				begin
					if (enter_green)
					begin
						resume_mode <= power;
						power <= tzrtc_green;
					end
					else if (setup_write && hit(paddr, `TZRTC_POWER_OFFSET))
						power <= wbyte[0] ? tzrtc_slow : tzrtc_normal;
				end
				tzrtc_green:
				begin
					if (overflow)
						power <= resume_mode;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_pulse <= 1'b0;
		else
			wake_pulse <= overflow && (power == tzrtc_green);
	end

	assign green_active = (power == tzrtc_green);
	assign power_mode = power;

	assign set_event.overflow = overflow;
	assign set_event.wake = overflow && (power == tzrtc_green);
	assign clear_event = (setup_write &&
		hit(paddr, `TZRTC_IRQ_CLEAR_OFFSET)) ? wbyte[1:0] : 2'b00;

	tzrtc_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.set_event(set_event),
		.clear_event(clear_event),
		.enable_write(setup_write && hit(paddr, `TZRTC_IRQ_ENABLE_OFFSET)),
		.enable_data(wbyte[1:0]),
		.status(status),
		.enable(enable),
		.irq(irq)
	);

	// Vector registered from the request, so it rises and falls one cycle after it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_vector <= 8'h00;
		else
			irq_vector <= (|(status & enable)) ? `TZRTC_VECTOR : 8'h00;
	end

	// Read data registered during setup, valid in access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (bus_read && !penable)
		begin
			prdata <= 32'h0000_0000;
			if (hit(paddr, `TZRTC_MODE_OFFSET))
				prdata[7:0] <= {mode.run, mode.prescale_select, 3'h0,
					mode.rtc_clock_select};
			else if (hit(paddr, `TZRTC_COUNT_OFFSET))
				prdata[7:0] <= timer_zero_count;
			else if (hit(paddr, `TZRTC_IRQ_STATUS_OFFSET))
				prdata[1:0] <= status;
			else if (hit(paddr, `TZRTC_IRQ_ENABLE_OFFSET))
				prdata[1:0] <= enable;
			else if (hit(paddr, `TZRTC_POWER_OFFSET))
				prdata[1:0] <= power;
		end
	end

endmodule : tzrtc_timer

// [testbench/timer_zero_interval_rtc_test.sv]
/*
 Self-checking bench for tzrtc_timer over APB.
 Assumes the design and checker files are compiled before it.
*/
`timescale 1ns/1ns
`include "tzrtc_params.svh"

module timer_zero_interval_rtc_test;
	// Byte address is four times the register index
	localparam logic [11:0] a_mode = `TZRTC_MODE_OFFSET << 2;
	localparam logic [11:0] a_count = `TZRTC_COUNT_OFFSET << 2;
	localparam logic [11:0] a_stat = `TZRTC_IRQ_STATUS_OFFSET << 2;
	localparam logic [11:0] a_clr = `TZRTC_IRQ_CLEAR_OFFSET << 2;
	localparam logic [11:0] a_en = `TZRTC_IRQ_ENABLE_OFFSET << 2;
	localparam logic [11:0] a_pwr = `TZRTC_POWER_OFFSET << 2;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic enter_green = 0, losc_tick = 0, rs, cpu_tick = 1;
	logic [3:0] pstrb = 4'hf;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv;
	logic [7:0] irq_vector;
	logic [1:0] power_mode, lc = 0;
	logic pready, pslverr, irq, green_active, wake_pulse;
	int err_total = 0, check_count = 0;

	initial
	begin
		forever #5 pclk = ~pclk;
	end
	// Slow oscillator pulse every fourth cycle
	always @(posedge pclk)
	begin
		lc <= lc + 2'd1;
		losc_tick <= lc == 2'd3;
	end

	tzrtc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_tick(cpu_tick), .losc_tick(losc_tick), .enter_green(enter_green),
		.irq(irq), .irq_vector(irq_vector), .green_active(green_active),
		.wake_pulse(wake_pulse), .power_mode(power_mode));

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n == 50)
		begin
			err_total++;
			complete_run();
		end
		rv = prdata;
		rs = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : bus

	task automatic wait_hi(ref logic s);
		int n;
		for (n = 0; n < 2000 && s !== 1'b1; n++)
			@(negedge pclk);
		if (n == 2000)
		begin
			err_total++;
			complete_run();
		end
		@(posedge pclk);
	endtask : wait_hi

	task automatic t_regs;
		bus(0, a_mode, 0);
		chk(rv, 32'h0);
		bus(0, a_count, 0);
		chk(rv, 32'h0);
		bus(0, 12'h100, 0);
		chk(rv, 32'h0);
		chk(rs, 32'h1);
		bus(1, a_mode, 32'h7e);
		bus(0, a_mode, 0);
		chk(rv, 32'h70);
		// Write without byte strobe must be ignored
		pstrb <= 4'h0;
		bus(1, a_mode, 32'h81);
		pstrb <= 4'hf;
		bus(0, a_mode, 0);
		chk(rv, 32'h70);
		$display("regs done");
	endtask : t_regs

	task automatic t_halt;
		logic [31:0] c;
		bus(1, a_count, 32'h42);
		repeat (600) @(posedge pclk);
		bus(0, a_count, 0);
		chk(rv, 32'h42);
		bus(1, a_mode, 32'hf0);
		bus(1, a_mode, 32'h70);
		bus(0, a_count, 0);
		c = rv;
		chk(c > 32'h42 && c < 32'h48, 1);
		repeat (50) @(posedge pclk);
		bus(0, a_count, 0);
		chk(rv, c);
		// Running but with no instruction ticks: no count
		cpu_tick <= 0;
		bus(1, a_mode, 32'hf0);
		repeat (20) @(posedge pclk);
		bus(1, a_mode, 32'h70);
		cpu_tick <= 1;
		bus(0, a_count, 0);
		chk(rv, c);
		$display("halt done");
	endtask : t_halt

	task automatic t_rates;
		for (int r = 0; r < 8; r++)
		begin
			bus(1, a_count, 0);
			bus(1, a_mode, r << 4);
			bus(1, a_mode, 32'h80 | r << 4);
			repeat (4 * (256 >> r) - 2) @(posedge pclk);
			bus(1, a_mode, 0);
			bus(0, a_count, 0);
			chk(rv == 3 || rv == 4, 1);
		end
		$display("rates done");
	endtask : t_rates

	task automatic t_irq;
		bus(1, a_en, 1);
		bus(1, a_count, 32'hff);
		bus(1, a_mode, 32'h70);
		bus(1, a_mode, 32'hf0);
		wait_hi(irq);
		@(negedge pclk);
		chk(irq_vector, 32'h08);
		@(posedge pclk);
		bus(1, a_mode, 0);
		bus(0, a_count, 0);
		chk(rv < 4, 1);
		repeat (20) @(posedge pclk);
		bus(0, a_stat, 0);
		chk(rv, 32'h1);
		bus(1, a_en, 0);
		chk(irq, 0);
		bus(1, a_en, 1);
		chk(irq, 1);
		bus(1, a_clr, 1);
		bus(0, a_stat, 0);
		chk(irq, 0);
		chk(rv, 32'h0);
		$display("irq done");
	endtask : t_irq

	task automatic t_green;
		bus(1, a_pwr, 1);
		enter_green <= 1;
		@(posedge pclk);
		enter_green <= 0;
		@(posedge pclk);
		bus(0, a_pwr, 0);
		chk(rv, 32'h2);
		bus(1, a_count, 32'hff);
		bus(1, a_mode, 32'h70);
		bus(1, a_mode, 32'hf0);
		wait_hi(wake_pulse);
		@(negedge pclk);
		chk(power_mode, 1);
		@(posedge pclk);
		bus(1, a_mode, 0);
		bus(0, a_stat, 0);
		chk(rv, 32'h3);
		bus(1, a_clr, 3);
		bus(1, a_pwr, 0);
		$display("green done");
	endtask : t_green

	task automatic t_rtc;
		bus(1, a_count, 0);
		bus(1, a_mode, 32'h7f);
		bus(1, a_mode, 32'hff);
		bus(0, a_mode, 0);
		chk(rv, 32'hf1);
		repeat (768) @(posedge pclk);
		bus(1, a_mode, 32'h71);
		bus(0, a_count, 0);
		chk(rv == 2 || rv == 3, 1);
		$display("rtc done");
	endtask : t_rtc

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs();
		t_halt();
		t_rates();
		t_irq();
		t_green();
		t_rtc();
		complete_run();
	end
endmodule : timer_zero_interval_rtc_test

// [testbench/tzrtc_timer_properties.sv]
/*
 Port checker for the interval timer.
 Assumes it is bound to every tzrtc_timer instance.
*/
`timescale 1ns/1ns

module tzrtc_timer_properties
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	input wire logic enter_green,
	input wire logic irq,
	input wire logic [7:0] irq_vector,
	input wire logic green_active,
	input wire logic wake_pulse,
	input wire logic [1:0] power_mode
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence access_s;
		psel && penable;
	endsequence
	sequence go_green_s;
		enter_green && !green_active;
	endsequence

	vector_set_a: assert property ($rose(irq) |=> irq_vector == 8'h08)
		else $error("vector missing after interrupt");
	wake_leave_a: assert property (wake_pulse |-> !green_active)
		else $error("still green at wake");
	wake_once_a: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake longer than one cycle");
	green_state_a: assert property (green_active == (power_mode == 2'h2))
		else $error("green flag and state differ");
	enter_green_a: assert property (go_green_s |=> green_active)
		else $error("green not entered");
	mode_legal_a: assert property (power_mode != 2'h3)
		else $error("illegal power state");
	err_map_a: assert property (access_s and paddr == 12'h100 |-> pslverr)
		else $error("unmapped access not refused");
	map_ok_a: assert property (access_s and paddr == 12'h364 |-> !pslverr)
		else $error("count access refused");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
endmodule : tzrtc_timer_properties

bind tzrtc_timer tzrtc_timer_properties chk_i (.*);
